// File: core/usp_serial_port.sv
// Four-mode serial port with an APB register slave.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module usp_serial_port
    import usp_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [APB_DW-1:0] pwdata,
    output logic      [APB_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Serial input pin, two-way in mode 0
    input  wire logic              serial_in_pin_i,
    output logic                   serial_in_pin_o,
    output logic                   serial_in_pin_oe,
    // Serial output pin, data or mode 0 shift clock
    output logic                   serial_out_pin_o,
    // Request levels
    output logic                   rx_irq,
    output logic                   tx_irq
);
    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ENG_IDLE     = 2'b00,
        ENG_ASYNC_TX = 2'b01,
        ENG_SYNC_TX  = 2'b10,
        ENG_SYNC_RX  = 2'b11
    } usp_eng_state_type;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10
    } usp_rx_state_type;

    usp_ctrl_high_type  ctrl_high_r;
    usp_ctrl_high_type  ctrl_high_nxt;
    usp_ctrl_low_type   ctrl_low_r;
    usp_ctrl_low_type   ctrl_low_nxt;
    logic [DIV_W-1:0]   divisor_r;
    logic [7:0]         tx_buf_r;
    logic [7:0]         rx_buf_r;
    logic [7:0]         rx_buf_nxt;
    logic               tx_hold_r;
    usp_eng_state_type  eng_r;
    usp_eng_state_type  eng_nxt;
    logic [3:0]         eng_tick_r;
    logic [3:0]         eng_tick_nxt;
    logic [3:0]         eng_bit_r;
    logic [3:0]         eng_bit_nxt;
    logic [10:0]        eng_sh_r;
    logic [10:0]        eng_sh_nxt;
    usp_rx_state_type   rx_r;
    usp_rx_state_type   rx_nxt;
    logic [3:0]         rx_tick_r;
    logic [3:0]         rx_tick_nxt;
    logic [3:0]         rx_bit_r;
    logic [3:0]         rx_bit_nxt;
    logic [8:0]         rx_sh_r;
    logic [8:0]         rx_sh_nxt;
    logic               rx_prev_r;
    logic               tick;
    logic               rx_s;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire                acc_wr      = psel && penable && pwrite;
    wire                hit_high    = (paddr == ADDR_SERIAL_CTRL_HIGH);
    wire                hit_low     = (paddr == ADDR_SERIAL_CTRL_LOW);
    wire                hit_data    = (paddr == ADDR_SERIAL_DATA_BUF);
    wire                hit_div     = (paddr == ADDR_BIT_RATE_DIV);
    wire                hit_any     = hit_high || hit_low || hit_data || hit_div;
    wire                wr_high     = acc_wr && hit_high;
    wire                wr_low      = acc_wr && hit_low;
    wire                wr_data     = acc_wr && hit_data;
    wire                wr_div      = acc_wr && hit_div;
    wire                setup_rd    = psel && !penable && !pwrite;
    wire [APB_DW-1:0]   rd_mux      = hit_high ? {24'h00_0000, ctrl_high_r} :
                                      hit_low  ? {24'h00_0000, ctrl_low_r} :
                                      hit_data ? {24'h00_0000, rx_buf_r} :
                                      hit_div  ? APB_DW'(divisor_r) : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // ----------------------------------------------------------------
    // Mode decode and shared timing
    // ----------------------------------------------------------------
    wire usp_mode_type  mode        = ctrl_high_r.mode;
    wire                mode_sync   = (mode == MODE_SYNC);
    wire                mode_nine   = (mode == MODE_FIXED9) || (mode == MODE_VAR9);
    wire                filt_en     = ctrl_high_r.multiproc_filter_enable;
    wire                rx_en       = ctrl_high_r.receive_enable_bit;
    wire [3:0]          tx_last     = mode_sync ? SYNC_LAST_BIT :
                                      mode_nine ? ASYNC9_LAST_BIT : ASYNC8_LAST_BIT;
    wire                tx_parity   = (^tx_buf_r) ^ ctrl_low_r.parity_odd;
    wire                tx_ninth    = ctrl_low_r.parity_enable ? tx_parity :
                                      ctrl_high_r.tx_ninth_bit;
    wire [10:0]         async_frame = mode_nine ? {1'b1, tx_ninth, tx_buf_r, 1'b0} :
                                      {2'b11, tx_buf_r, 1'b0};
    wire                eng_end_bit = tick && (eng_tick_r == TICK_LAST);
    wire                eng_mid_bit = tick && (eng_tick_r == TICK_MID);
    wire                hold_take   = (eng_r == ENG_IDLE) && tx_hold_r;

    usp_tick_gen #(
        .DIV_W        (DIV_W),
        .PRE_W        (3)
    ) u_tick (
        .pclk         (pclk),
        .presetn      (presetn),
        .clock_select (ctrl_low_r.clock_select),
        .divisor      (divisor_r),
        .fixed_rate   (mode == MODE_FIXED9),
        .tick         (tick)
    );

    usp_sync2 #(
        .W            (1)
    ) u_rx_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .async_in     (serial_in_pin_i),
        .rst_val      (1'b1),
        .sync_out     (rx_s)
    );

    // ----------------------------------------------------------------
    // Line engine: async transmit and both mode 0 directions
    // ----------------------------------------------------------------
    logic tx_set;
    logic sync_rx_done;

    always_comb begin
        eng_nxt      = eng_r;
        eng_tick_nxt = tick ? 4'(eng_tick_r + 4'h1) : eng_tick_r;
        eng_bit_nxt  = eng_bit_r;
        eng_sh_nxt   = eng_sh_r;
        tx_set       = 1'b0;
        sync_rx_done = 1'b0;
        unique case (eng_r)
            ENG_IDLE: begin
                eng_tick_nxt = 4'h0;
                eng_bit_nxt  = 4'h0;
                if (tx_hold_r) begin
                    if (mode_sync) begin
                        eng_nxt    = ENG_SYNC_TX;
                        eng_sh_nxt = {3'b111, tx_buf_r};
                    end else begin
                        eng_nxt    = ENG_ASYNC_TX;
                        eng_sh_nxt = async_frame;
                    end
                end else if (mode_sync && rx_en && !ctrl_high_r.rx_pending) begin
                    eng_nxt = ENG_SYNC_RX;
                end
            end
            ENG_ASYNC_TX: begin
                if (eng_end_bit) begin
                    eng_sh_nxt  = {1'b1, eng_sh_r[10:1]};
                    eng_bit_nxt = 4'(eng_bit_r + 4'h1);
                    tx_set      = (eng_bit_r == 4'(tx_last - 4'h1));
                    if (eng_bit_r == tx_last) begin
                        eng_nxt = ENG_IDLE;
                    end
                end
            end
            ENG_SYNC_TX: begin
                if (eng_end_bit) begin
                    eng_sh_nxt  = {1'b1, eng_sh_r[10:1]};
                    eng_bit_nxt = 4'(eng_bit_r + 4'h1);
                    if (eng_bit_r == SYNC_LAST_BIT) begin
                        eng_nxt = ENG_IDLE;
                        tx_set  = 1'b1;
                    end
                end
            end
            ENG_SYNC_RX: begin
                if (eng_mid_bit) begin
                    eng_sh_nxt = {eng_sh_r[10:8], rx_s, eng_sh_r[7:1]};
                end
                if (eng_end_bit) begin
                    eng_bit_nxt = 4'(eng_bit_r + 4'h1);
                    if (eng_bit_r == SYNC_LAST_BIT) begin
                        eng_nxt      = ENG_IDLE;
                        sync_rx_done = 1'b1;
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Asynchronous receiver
    // ----------------------------------------------------------------
    logic async_rx_done;
    wire  rx_fall = rx_prev_r && !rx_s;

    always_comb begin
        rx_nxt        = rx_r;
        rx_tick_nxt   = tick ? 4'(rx_tick_r + 4'h1) : rx_tick_r;
        rx_bit_nxt    = rx_bit_r;
        rx_sh_nxt     = rx_sh_r;
        async_rx_done = 1'b0;
        unique case (rx_r)
            RX_IDLE: begin
                rx_tick_nxt = 4'h0;
                rx_bit_nxt  = 4'h0;
                if (!mode_sync && rx_en && rx_fall) begin
                    rx_nxt = RX_START;
                end
            end
            RX_START: begin
                if (tick && rx_tick_r == TICK_MID) begin
                    rx_tick_nxt = 4'h0;
                    rx_nxt      = rx_s ? RX_IDLE : RX_BITS;
                end
            end
            RX_BITS: begin
                if (tick && rx_tick_r == TICK_LAST) begin
                    rx_sh_nxt  = {rx_s, rx_sh_r[8:1]};
                    rx_bit_nxt = 4'(rx_bit_r + 4'h1);
                    if (rx_bit_r == RX_LAST_SAMPLE) begin
                        rx_nxt        = RX_IDLE;
                        async_rx_done = 1'b1;
                    end
                end
            end
            default: begin
                rx_nxt = RX_IDLE;
            end
        endcase
        if (mode_sync) begin
            rx_nxt = RX_IDLE;
        end
    end

    // Sample 8 is the stop bit in mode 1 and the ninth bit in modes 2 and 3.
    wire last_sample = rx_sh_nxt[8];
    wire async_ok    = !filt_en || last_sample;
    wire rx_accept   = sync_rx_done || (async_rx_done && async_ok);
    assign rx_buf_nxt = sync_rx_done ? eng_sh_r[7:0] : rx_sh_nxt[7:0];

    // ----------------------------------------------------------------
    // Control register next values
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_high_nxt = ctrl_high_r;
        ctrl_low_nxt  = ctrl_low_r;
        if (wr_high) begin
            ctrl_high_nxt = usp_ctrl_high_type'(pwdata[7:0]);
        end
        if (wr_low) begin
            ctrl_low_nxt          = usp_ctrl_low_type'(pwdata[7:0]);
            ctrl_low_nxt.reserved = 2'b00;
        end
        if (rx_accept) begin
            ctrl_high_nxt.rx_pending = 1'b1;
        end
        if (async_rx_done && async_ok && mode_nine) begin
            ctrl_high_nxt.rx_ninth_bit = last_sample;
        end
        if (tx_set) begin
            ctrl_low_nxt.tx_pending = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_high_r <= usp_ctrl_high_type'(RST_CTRL_HIGH);
            ctrl_low_r  <= usp_ctrl_low_type'(RST_CTRL_LOW);
            divisor_r   <= DIV_W'(RST_DIVISOR);
            tx_buf_r    <= RST_DATA;
            rx_buf_r    <= RST_DATA;
            tx_hold_r   <= 1'b0;
            prdata      <= 32'h0000_0000;
        end else begin
            ctrl_high_r <= ctrl_high_nxt;
            ctrl_low_r  <= ctrl_low_nxt;
            divisor_r   <= wr_div ? pwdata[DIV_W-1:0] : divisor_r;
            tx_buf_r    <= wr_data ? pwdata[7:0] : tx_buf_r;
            rx_buf_r    <= rx_accept ? rx_buf_nxt : rx_buf_r;
            tx_hold_r   <= wr_data || (tx_hold_r && !hold_take);
            prdata      <= setup_rd ? rd_mux : prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_r      <= ENG_IDLE;
            eng_tick_r <= 4'h0;
            eng_bit_r  <= 4'h0;
            eng_sh_r   <= 11'h7FF;
        end else begin
            eng_r      <= eng_nxt;
            eng_tick_r <= eng_tick_nxt;
            eng_bit_r  <= eng_bit_nxt;
            eng_sh_r   <= eng_sh_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_r      <= RX_IDLE;
            rx_tick_r <= 4'h0;
            rx_bit_r  <= 4'h0;
            rx_sh_r   <= 9'h1FF;
            rx_prev_r <= 1'b1;
        end else begin
            rx_r      <= rx_nxt;
            rx_tick_r <= rx_tick_nxt;
            rx_bit_r  <= rx_bit_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_prev_r <= rx_s;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    wire sync_active = (eng_r == ENG_SYNC_TX) || (eng_r == ENG_SYNC_RX);
    wire out_nxt     = sync_active ? eng_tick_r[3] :
                       (eng_r == ENG_ASYNC_TX) ? eng_sh_r[0] : 1'b1;
    wire in_drv_nxt  = (eng_r == ENG_SYNC_TX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin_o <= 1'b1;
            serial_in_pin_o  <= 1'b1;
            serial_in_pin_oe <= 1'b0;
        end else begin
            serial_out_pin_o <= out_nxt;
            serial_in_pin_o  <= in_drv_nxt ? eng_sh_r[0] : 1'b1;
            serial_in_pin_oe <= in_drv_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Request levels
    // ----------------------------------------------------------------
    assign rx_irq = ctrl_high_r.rx_pending && ctrl_high_r.rx_irq_enable;
    assign tx_irq = ctrl_low_r.tx_pending && ctrl_low_r.tx_irq_enable;

    generate
        if (DIV_W < 1 || DIV_W > 24) begin : g_bad_div
            $error("usp_serial_port divisor width must be 1 to 24");
        end
    endgenerate
endmodule // usp_serial_port

// File: core/usp_pkg.sv
// Shared constants, register map and carrier types for the four-mode serial port.
package usp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          APB_AW              = 12;
    localparam int          APB_DW              = 32;
    localparam logic [9:0]  IDX_SERIAL_CTRL_HIGH = 10'h014;
    localparam logic [9:0]  IDX_SERIAL_CTRL_LOW  = 10'h015;
    localparam logic [9:0]  IDX_SERIAL_DATA_BUF  = 10'h016;
    localparam logic [9:0]  IDX_BIT_RATE_DIV     = 10'h017;
    localparam logic [11:0] ADDR_SERIAL_CTRL_HIGH = {IDX_SERIAL_CTRL_HIGH, 2'b00};
    localparam logic [11:0] ADDR_SERIAL_CTRL_LOW  = {IDX_SERIAL_CTRL_LOW, 2'b00};
    localparam logic [11:0] ADDR_SERIAL_DATA_BUF  = {IDX_SERIAL_DATA_BUF, 2'b00};
    localparam logic [11:0] ADDR_BIT_RATE_DIV     = {IDX_BIT_RATE_DIV, 2'b00};

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL_HIGH       = 8'h00;
    localparam logic [7:0]  RST_CTRL_LOW        = 8'h00;
    localparam logic [7:0]  RST_DIVISOR         = 8'h00;
    localparam logic [7:0]  RST_DATA            = 8'h00;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam int          OVERSAMPLE          = 16;
    localparam logic [3:0]  TICK_LAST           = 4'(OVERSAMPLE - 1);
    localparam logic [3:0]  TICK_MID            = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0]  SYNC_LAST_BIT       = 4'h7;
    localparam logic [3:0]  ASYNC8_LAST_BIT     = 4'h9;
    localparam logic [3:0]  ASYNC9_LAST_BIT     = 4'hA;
    localparam logic [3:0]  RX_LAST_SAMPLE      = 4'h8;

    // ----------------------------------------------------------------
    // Modes and field layouts
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SYNC   = 2'b00,
        MODE_ASYNC8 = 2'b01,
        MODE_FIXED9 = 2'b10,
        MODE_VAR9   = 2'b11
    } usp_mode_type;

    typedef struct packed {
        usp_mode_type mode;
        logic         multiproc_filter_enable;
        logic         receive_enable_bit;
        logic         tx_ninth_bit;
        logic         rx_ninth_bit;
        logic         rx_irq_enable;
        logic         rx_pending;
    } usp_ctrl_high_type;

    typedef struct packed {
        logic         parity_enable;
        logic         parity_odd;
        logic [1:0]   reserved;
        logic [1:0]   clock_select;
        logic         tx_irq_enable;
        logic         tx_pending;
    } usp_ctrl_low_type;

endpackage : usp_pkg

// File: core/usp_sync2.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/1ps
module usp_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_r;

    // Both stages reset high so an idle line is not mistaken for a start bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r <= '1;
            sync_out <= '1;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

    generate
        if (W < 1) begin : g_bad_width
            $error("usp_sync2 width must be at least one");
        end
    endgenerate
endmodule // usp_sync2

// File: core/usp_tick_gen.sv
// Oversample tick generator: clock prescaler followed by the bit rate divisor.
`timescale 1ns/1ps
module usp_tick_gen
    import usp_pkg::*;
#(
    parameter int DIV_W = 8,
    parameter int PRE_W = 3
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Configuration
    input  wire logic [1:0]       clock_select,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             fixed_rate,
    // Tick out
    output logic                  tick
);
    logic [PRE_W-1:0] pre_cnt_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic [PRE_W-1:0] pre_max;
    logic             pre_hit;
    logic             div_hit;

    assign pre_max = PRE_W'((1 << clock_select) - 1);
    assign pre_hit = (pre_cnt_r >= pre_max);
    assign div_hit = (div_cnt_r >= divisor);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r <= '0;
            div_cnt_r <= '0;
            tick      <= 1'b0;
        end else begin
            pre_cnt_r <= pre_hit ? '0 : PRE_W'(pre_cnt_r + 1'b1);
            if (pre_hit) begin
                div_cnt_r <= (div_hit || fixed_rate) ? '0 : DIV_W'(div_cnt_r + 1'b1);
            end
            tick <= pre_hit && (fixed_rate || div_hit);
        end
    end

    generate
        if (PRE_W < 3 || DIV_W < 1) begin : g_bad_width
            $error("usp_tick_gen prescaler needs three bits and divisor one");
        end
    endgenerate
endmodule // usp_tick_gen

// File: tb/usp_checker.sv
// Port assertions for the four-mode serial port.
`timescale 1ns/1ps
module usp_checker
    import usp_pkg::*;
(
    // Clock, reset and APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    // Pins and requests
    input wire logic              serial_in_pin_o,
    input wire logic              serial_in_pin_oe,
    input wire logic              serial_out_pin_o,
    input wire logic              rx_irq,
    input wire logic              tx_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic  wr_ok = psel && penable && pwrite;
    wire logic  wr_hi = wr_ok && paddr == ADDR_SERIAL_CTRL_HIGH;
    logic [1:0] mode_r;
    // Mode field as last written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 2'h0;
        end else if (wr_hi) begin
            mode_r <= pwdata[7:6];
        end
    end
    property p_oe_mode; serial_in_pin_oe |-> mode_r == 2'h0; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin driven outside mode 0");
    property p_o_idle; !serial_in_pin_oe |-> serial_in_pin_o; endproperty
    a_o_idle: assert property (p_o_idle) else $error("undriven pin output low");
    property p_low; $fell(serial_out_pin_o) |=> !serial_out_pin_o [*7]; endproperty
    a_low: assert property (p_low) else $error("low phase too short");
    property p_high; $rose(serial_out_pin_o) |=> serial_out_pin_o [*7]; endproperty
    a_high: assert property (p_high) else $error("high phase too short");
    property p_txirq; $rose(tx_irq) |-> ##[0:2] serial_out_pin_o; endproperty
    a_txirq: assert property (p_txirq) else $error("tx request outside stop bit");
    property p_rxmask; wr_hi && !pwdata[1] |=> !rx_irq; endproperty
    a_rxmask: assert property (p_rxmask) else $error("rx request while masked");
    property p_txmask;
        wr_ok && paddr == ADDR_SERIAL_CTRL_LOW && !pwdata[1] |=> !tx_irq;
    endproperty
    a_txmask: assert property (p_txmask) else $error("tx request while masked");
    property p_rst; $rose(presetn) |-> !rx_irq && !tx_irq; endproperty
    a_rst: assert property (p_rst) else $error("request after reset");
endmodule // usp_checker

bind usp_serial_port usp_checker usp_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .serial_in_pin_o(serial_in_pin_o), .serial_in_pin_oe(serial_in_pin_oe),
    .serial_out_pin_o(serial_out_pin_o), .rx_irq(rx_irq), .tx_irq(tx_irq));

// File: tb/usp_peer.sv
// Remote serial peer: frame sender, frame catcher and mode 0 data source.
`timescale 1ns/1ps
module usp_peer (
    // Clock and bit time in clocks
    input  wire logic        pclk,
    input  wire logic [7:0]  bt,
    // Line
    input  wire logic        tx_line,
    output logic             line_out,
    output logic      [10:0] cap
);
    initial line_out = 1'b1;
    // Sends one 11-bit frame LSB first, then idles high.
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (bt) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask
    // Waits for a start bit, then samples 11 bits at their centres.
    task automatic grab();
        int k;
        k = 0;
        while (tx_line !== 1'b0 && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            cap[i] = tx_line;
            repeat (bt) @(posedge pclk);
        end
    endtask
    // Holds each bit to the next rising shift clock, then drives the inverse.
    task automatic shift0(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            line_out <= v[i];
            @(posedge tx_line);
        end
        line_out <= ~v[7];
    endtask
endmodule // usp_peer

// File: tb/testbench.sv
// Self-checking bench for the four-mode serial port.
`timescale 1ns/1ps
module testbench;
    import usp_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rdv, d;
    logic              s_o, s_oe, tx_pin, rx_irq, tx_irq, peer_o, nine, take;
    logic [7:0]        bt, last, sh;
    logic [10:0]       cap;
    wire logic         rx_line = s_oe ? s_o : peer_o;
    int                errors, n_compared, seed, cyc, m;
    logic [11:0]       regs [5] = '{ADDR_SERIAL_CTRL_HIGH, ADDR_SERIAL_CTRL_LOW,
                                    ADDR_SERIAL_DATA_BUF, ADDR_BIT_RATE_DIV, 12'h0fc};
    usp_serial_port #(.DIV_W(8)) usp_serial_port_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin_i(rx_line),
        .serial_in_pin_o(s_o), .serial_in_pin_oe(s_oe), .serial_out_pin_o(tx_pin),
        .rx_irq(rx_irq), .tx_irq(tx_irq));
    usp_peer usp_peer_inst (.pclk(pclk), .bt(bt), .tx_line(tx_pin), .line_out(peer_o),
        .cap(cap));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        chk({31'h0, pslverr}, {31'h0, a == 12'h0fc});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        bt = 8'h10;
        last = 8'h00;
        seed = 32'ha037;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rdv, 32'h0);
        end
        $display("reset values done");
        apb(1'b1, ADDR_BIT_RATE_DIV, 32'h1);
        for (int k = 1; k < 4; k++) begin
            d = $random(seed);
            nine = (k > 1 && d[8]) ? ^d[7:0] ^ d[9] : d[10];
            apb(1'b1, ADDR_SERIAL_CTRL_LOW, {24'h0, k > 1 && d[8], d[9], 6'h02});
            apb(1'b1, ADDR_SERIAL_CTRL_HIGH, {24'h0, 2'(k), 2'h0, d[10], 3'h0});
            bt = (k == 2) ? 8'h10 : 8'h20;
            fork
                usp_peer_inst.grab();
                apb(1'b1, ADDR_SERIAL_DATA_BUF, d);
            join
            chk({21'h0, cap}, {21'h0, 1'b1, k == 1 || nine, d[7:0], 1'b0});
            chk({31'h0, tx_irq}, 32'h1);
        end
        $display("async transmit done");
        for (int k = 0; k < 6; k++) begin
            m = k % 3 + 1;
            d = $random(seed);
            bt = (m == 2) ? 8'h20 : 8'h40;
            take = !(d[9] && !d[8]);
            apb(1'b1, ADDR_SERIAL_CTRL_LOW, 32'h4);
            apb(1'b1, ADDR_SERIAL_CTRL_HIGH, {24'h0, 2'(m), d[9], 1'b1, 2'h0, 2'h2});
            usp_peer_inst.send({1'b1, d[8:0], 1'b0});
            repeat (8) @(posedge pclk);
            if (take) last = d[7:0];
            apb(1'b0, ADDR_SERIAL_DATA_BUF, 32'h0);
            if (m > 1 || take) chk(rdv, {24'h0, last});
            apb(1'b0, ADDR_SERIAL_CTRL_HIGH, 32'h0);
            chk({30'h0, rdv[0], rx_irq}, {30'h0, take, take});
            if (m > 1 && take) chk({31'h0, rdv[2]}, {31'h0, d[8]});
        end
        $display("async receive done");
        apb(1'b1, ADDR_SERIAL_CTRL_HIGH, 32'h0);
        d = $random(seed);
        fork
            apb(1'b1, ADDR_SERIAL_DATA_BUF, d);
            for (int i = 0; i < 8; i++) begin
                @(posedge tx_pin);
                sh[i] = rx_line;
            end
        join
        chk({24'h0, sh}, {24'h0, d[7:0]});
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_SERIAL_CTRL_LOW, 32'h0);
        chk({31'h0, rdv[0]}, 32'h1);
        d = $random(seed);
        fork
            usp_peer_inst.shift0(d[7:0]);
            apb(1'b1, ADDR_SERIAL_CTRL_HIGH, 32'h32);
        join
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_SERIAL_DATA_BUF, 32'h0);
        chk(rdv, {24'h0, d[7:0]});
        chk({31'h0, rx_irq}, 32'h1);
        $display("mode 0 done");
        end_of_test();
    end
endmodule // testbench
